// ===== logic/vm_assist_params.svh
// offsets, field positions, reset values and codes for the vm assist sequencer
`ifndef VM_ASSIST_PARAMS_SVH
`define VM_ASSIST_PARAMS_SVH
`define REG_CTRL6        8'h00
`define REG_STATUS       8'h04
`define REG_INSTR_HI     8'h08
`define REG_INSTR_LO     8'h0C
`define REG_DISPOSITION  8'h10
`define REG_GUEST_TIMER  8'h14
`define REG_GUEST_CTRL   8'h18
`define REG_TIMER_CODE   8'h1C
`define REG_LEVEL        8'h20
`define CR6_VMA_BIT      0
`define CR6_CPA_BIT      6
`define CR6_VIT_BIT      7
`define CR6_RESET        32'h00000000
`define ASSIST_OPCODE    8'hE6
`define OP_LOAD_STATUS_WORD_INSTR          8'h82
`define OP_SSM           8'h80
`define OP_STORE_THEN_AND_MASK_INSTR         8'hAC
`define OP_STORE_THEN_OR_MASK_INSTR         8'hAD
`define OP_B2            8'hB2
`define SUB_SET_CLOCK_COMPARATOR_INSTR         8'h06
`define SUB_SIO          8'h04
`define SUB_SPT          8'h08
`define SUB_PURGE_TRANSLATION_BUFFER_INSTR         8'h0D
`define SUB_STORE_CPU_TIMER_INSTR         8'h09
`define OP_TCH           8'h9F
`define OP_SVC           8'h0A
`define SVC_LINK         8'h08
`define SVC_RETURN       8'h0C
`define EXT_LEVEL_CODE   8'h1E
`define TIMER_DECR_BIT   23
`define VTIMER_EXT_CODE  16'h0081
`define RTIMER_EXT_CODE  16'h0080
`endif

// ===== logic/vm_assist_pkg.sv
// types shared by the vm assist sequencer
package vm_assist_pkg;
	typedef enum logic [2:0] {
		DISP_NONE,
		DISP_SIMULATED,
		DISP_PARTIAL,
		DISP_PRIV_EXC,
		DISP_OPER_EXC,
		DISP_NOP,
		DISP_ASSIST_DONE
	} disposition_t;
	typedef enum logic [1:0] {
		TDEL_NONE,
		TDEL_GUEST,
		TDEL_REAL
	} timer_dest_t;
endpackage

// ===== logic/assist_func_unit.sv
// hypervisor-assist function selector, decoded from the extended opcode byte
`timescale 1ns/1ps
`include "vm_assist_params.svh"
module assist_func_unit #(
	parameter logic [31:0] LEVEL_ID = 32'h00000001 // arbitrary assist level value
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic [7:0]  ext_op,
	output logic             done,
	output logic             known,
	output logic [31:0]      level_value
);
	// one-cycle execution; function classes are recognised by extended opcode range
	function automatic logic known_op(input logic [7:0] op);
		known_op = (op <= 8'h1E);
	endfunction

	// completion pulse and the level word written by the store-assist-level function
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done        <= 1'b0;
			known       <= 1'b0;
			level_value <= 32'h00000000;
		end else begin
			done  <= start;
			known <= start & known_op(ext_op);
			if (start && ext_op == `EXT_LEVEL_CODE) begin
				level_value <= LEVEL_ID; // RULE11
			end
		end
	end
endmodule

// ===== logic/guest_timer.sv
// guest virtual interval timer with positive-to-negative detection
`timescale 1ns/1ps
`include "vm_assist_params.svh"
module guest_timer (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        load,
	input  wire logic [31:0] load_value,
	input  wire logic        tick,
	output logic [31:0]      value,
	output logic             crossed
);
	localparam logic [31:0] DECR = 32'h1 << (31 - `TIMER_DECR_BIT);
	logic [31:0] value_nxt;

	// bit 23 in big-endian numbering is weight 2^8 here
	always_comb begin
		value_nxt = value - DECR; // RULE15
	end

	// sign going 0 to 1 marks positive to negative
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value   <= 32'h00000000;
			crossed <= 1'b0;
		end else begin
			crossed <= 1'b0;
			if (load) begin
				value <= load_value;
			end else if (tick) begin
				value   <= value_nxt;
				crossed <= ~value[31] & value_nxt[31]; // RULE18 RULE24
			end
		end
	end
endmodule

// ===== logic/vm_assist_sequencer.sv
// vm assist sequencer: instruction interception, assist instructions, guest timer
// Functional notes
// RULE1 - status-word and mask instructions try basic assist first, expanded only on failure
// RULE2 - expanded assist failing raises privileged-operation exception to hypervisor
// RULE3 - purge buffer, store cpu timer, test channel fully simulated here
// RULE4 - other intercepted instructions partly simulated; hypervisor finishes them
// RULE5 - expanded assist reuses assist unit; basic and assist unit independent
// RULE6 - assist instruction acts only when enabled and in supervisor state
// RULE7 - assist present but disabled in supervisor state executes as no-op
// RULE8 - build without assist unit raises operation exception
// RULE9 - assist instructions are six-byte storage-to-storage with one opcode
// RULE10 - extended opcode byte selects the individual assist function
// RULE11 - store-assist-level writes architecture level of the assist
// RULE12 - hypervisor calls 08 and 0C executed as link and return when enabled
// RULE13 - timer assist active only with control bits 0 and 7; independent
// RULE14 - guest timer is word at location 80 of guest page 0
// RULE15 - in problem state decrement guest timer at bit 23 per real tick
// RULE16 - page 0 absent: timer word held in guest control block
// RULE17 - during wait state the guest timer is left unchanged
// RULE18 - positive to negative transition raises timer interruption condition
// RULE19 - deliver to guest only if enabled, resident, valid new psw, legal
// RULE20 - otherwise present to real machine if it is enabled for timer
// RULE21 - distinct external code marks virtual timer interruptions
// RULE22 - basic-control and extended-control guests are both supported
// RULE23 - reset clears control bits 0, 6 and 7
// RULE24 - timer is 32-bit twos complement; sign change marks crossing
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "vm_assist_params.svh"
module vm_assist_sequencer #(
	parameter bit HAS_ASSIST_UNIT = 1'b1
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        instr_valid,
	input  wire logic [47:0] instr_bytes,
	input  wire logic        guest_issued,
	input  wire logic        supervisor_state,
	input  wire logic        basic_can_simulate,
	input  wire logic        expanded_can_simulate,
	input  wire logic        real_timer_tick,
	input  wire logic        problem_state,
	input  wire logic        wait_state,
	input  wire logic        page0_resident,
	input  wire logic        guest_timer_enabled,
	input  wire logic        guest_new_psw_valid,
	input  wire logic        guest_state_change_legal,
	input  wire logic        real_timer_enabled,
	output logic             instr_done,
	output vm_assist_pkg::disposition_t disposition,
	output logic             timer_irq_guest,
	output logic             timer_irq_real,
	output logic [15:0]      ext_irq_code
);
	logic [31:0] ctrl6_r;
	logic [31:0] page0_word_r;
	logic [31:0] block_word_r;
	logic        aw_held_r;
	logic        w_held_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic [47:0] last_instr_r;
	logic        au_pending_r;
	logic        timer_pending_r;
	logic        page0_prev_r;
	logic        au_start;
	logic        au_done;
	logic        au_known;
	logic [31:0] au_level;
	logic [31:0] tmr_value;
	logic        tmr_crossed;
	logic        tmr_load;
	logic [31:0] tmr_load_value;
	logic        cpa_en;
	logic        vma_en;
	logic        vit_en;
	logic        wr_fire;
	logic [7:0]  op;
	logic [7:0]  sub;

	// merge byte lanes of a write into a register word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				old[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		merge = old;
	endfunction

	// control register 6 enables
	assign vma_en = ctrl6_r[`CR6_VMA_BIT];
	assign cpa_en = ctrl6_r[`CR6_CPA_BIT];
	assign vit_en = vma_en & ctrl6_r[`CR6_VIT_BIT]; // RULE13
	assign op     = instr_bytes[47:40];
	assign sub    = instr_bytes[39:32];

	// write channel accepts address and data in either order
	assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
	assign wr_fire       = (aw_held_r | s_axi_awvalid) & (w_held_r | s_axi_wvalid) & ~s_axi_bvalid;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h00000000;
			wstrb_r   <= 4'h0;
		end else if (wr_fire) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
		end
	end

	// write response; only control register 6 answers okay, every other address answers slverr
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= ((aw_held_r ? awaddr_r : s_axi_awaddr) == `REG_CTRL6) ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control register 6, cleared by processor reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl6_r <= `CR6_RESET; // RULE23
		end else if (wr_fire && (aw_held_r ? awaddr_r : s_axi_awaddr) == `REG_CTRL6) begin
			ctrl6_r <= merge(ctrl6_r, w_held_r ? wdata_r : s_axi_wdata,
				w_held_r ? wstrb_r : s_axi_wstrb);
		end
	end

	// read channel, one read at a time
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'b00;
			case (s_axi_araddr)
				`REG_CTRL6:       s_axi_rdata <= ctrl6_r;
				`REG_STATUS:      s_axi_rdata <= {28'h0, vit_en, cpa_en, vma_en, au_pending_r};
				`REG_INSTR_HI:    s_axi_rdata <= {16'h0000, last_instr_r[47:32]};
				`REG_INSTR_LO:    s_axi_rdata <= last_instr_r[31:0];
				`REG_DISPOSITION: s_axi_rdata <= {29'h0, disposition};
				`REG_GUEST_TIMER: s_axi_rdata <= page0_word_r;
				`REG_GUEST_CTRL:  s_axi_rdata <= block_word_r;
				`REG_TIMER_CODE:  s_axi_rdata <= {16'h0000, ext_irq_code};
				`REG_LEVEL:       s_axi_rdata <= au_level;
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// assist unit start: single opcode, six-byte format, enabled and supervisor
	assign au_start = instr_valid & (op == `ASSIST_OPCODE) & ~guest_issued & supervisor_state
		& cpa_en & (HAS_ASSIST_UNIT == 1'b1) & ~au_pending_r; // RULE6 RULE9

	assist_func_unit u_func (
		.clk         (clk),
		.rst_n       (rst_n),
		.start       (au_start),
		.ext_op      (sub), // RULE10
		.done        (au_done),
		.known       (au_known),
		.level_value (au_level)
	);

	// interception and disposition of each issued instruction
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			disposition  <= vm_assist_pkg::DISP_NONE;
			instr_done   <= 1'b0;
			au_pending_r <= 1'b0;
			last_instr_r <= 48'h000000000000;
		end else begin
			instr_done <= 1'b0;
			if (au_done) begin
				au_pending_r <= 1'b0;
				instr_done   <= 1'b1;
				disposition  <= au_known ? vm_assist_pkg::DISP_ASSIST_DONE
					: vm_assist_pkg::DISP_OPER_EXC; // RULE10
			end else if (instr_valid && !au_pending_r) begin
				last_instr_r <= instr_bytes;
				instr_done   <= ~au_start;
				if (au_start) begin
					au_pending_r <= 1'b1;
				end else if (op == `ASSIST_OPCODE) begin
					if (HAS_ASSIST_UNIT == 1'b0) begin
						disposition <= vm_assist_pkg::DISP_OPER_EXC; // RULE8
					end else if (supervisor_state && !guest_issued) begin
						disposition <= vm_assist_pkg::DISP_NOP; // RULE7
					end else begin
						disposition <= vm_assist_pkg::DISP_PRIV_EXC;
					end
				end else if (op == `OP_SVC && !guest_issued && cpa_en
					&& (sub == `SVC_LINK || sub == `SVC_RETURN)) begin
					disposition <= vm_assist_pkg::DISP_ASSIST_DONE; // RULE12
				end else if (!guest_issued || !vma_en) begin
					disposition <= vm_assist_pkg::DISP_NONE;
				end else if (op == `OP_LOAD_STATUS_WORD_INSTR || op == `OP_SSM || op == `OP_STORE_THEN_AND_MASK_INSTR
					|| op == `OP_STORE_THEN_OR_MASK_INSTR) begin
					if (basic_can_simulate) begin
						disposition <= vm_assist_pkg::DISP_SIMULATED; // RULE1
					end else if (cpa_en && expanded_can_simulate) begin
						disposition <= vm_assist_pkg::DISP_PARTIAL; // RULE1 RULE4 RULE5
					end else begin
						disposition <= vm_assist_pkg::DISP_PRIV_EXC; // RULE2
					end
				end else if (cpa_en && ((op == `OP_B2 && (sub == `SUB_PURGE_TRANSLATION_BUFFER_INSTR || sub == `SUB_STORE_CPU_TIMER_INSTR))
					|| op == `OP_TCH)) begin
					disposition <= vm_assist_pkg::DISP_SIMULATED; // RULE3
				end else if (cpa_en && op == `OP_B2 && (sub == `SUB_SET_CLOCK_COMPARATOR_INSTR || sub == `SUB_SIO
					|| sub == `SUB_SPT) && expanded_can_simulate) begin
					disposition <= vm_assist_pkg::DISP_PARTIAL; // RULE4
				end else begin
					disposition <= vm_assist_pkg::DISP_PRIV_EXC; // RULE2
				end
			end
		end
	end

	// page 0 arrival moves the held word back into the timer
	// resets to resident so a page already present gives no false arrival after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			page0_prev_r <= 1'b1;
		end else begin
			page0_prev_r <= page0_resident;
		end
	end
	assign tmr_load       = page0_resident & ~page0_prev_r; // RULE16
	assign tmr_load_value = block_word_r;

	// ticks only in problem state, not in wait; mode of guest is irrelevant
	guest_timer u_timer (
		.clk        (clk),
		.rst_n      (rst_n),
		.load       (tmr_load),
		.load_value (tmr_load_value),
		.tick       (vit_en & real_timer_tick & problem_state & ~wait_state), // RULE15 RULE17 RULE22
		.value      (tmr_value),
		.crossed    (tmr_crossed)
	);

	// location 80 image updated only while resident, control block copy updated whether resident or not
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			page0_word_r <= 32'h00000000;
			block_word_r <= 32'h00000000;
		end else if (page0_resident) begin
			page0_word_r <= tmr_value; // RULE14
			block_word_r <= tmr_value;
		end else begin
			block_word_r <= tmr_value; // RULE16
		end
	end

	// interruption routing: guest first, else real machine; set wins over hold
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_pending_r <= 1'b0;
			timer_irq_guest <= 1'b0;
			timer_irq_real  <= 1'b0;
			ext_irq_code    <= 16'h0000;
		end else begin
			timer_irq_guest <= 1'b0;
			timer_irq_real  <= 1'b0;
			if (timer_pending_r || tmr_crossed) begin
				if (guest_timer_enabled && page0_resident && guest_new_psw_valid
					&& guest_state_change_legal) begin
					timer_irq_guest <= 1'b1; // RULE19
					timer_pending_r <= 1'b0;
					ext_irq_code    <= `RTIMER_EXT_CODE;
				end else if (real_timer_enabled) begin
					timer_irq_real  <= 1'b1; // RULE20
					timer_pending_r <= 1'b0;
					ext_irq_code    <= `VTIMER_EXT_CODE; // RULE21
				end else begin
					timer_pending_r <= vit_en; // RULE13
				end
			end
		end
	end
endmodule

// ===== sim/vm_assist_props.sv
// concurrent checks on the vm assist sequencer ports
`timescale 1ns/1ps
`include "vm_assist_params.svh"
module vm_assist_props (
	input wire logic                        clk,
	input wire logic                        rst_n,
	input wire logic                        instr_valid,
	input wire logic [47:0]                 instr_bytes,
	input wire logic                        instr_done,
	input wire vm_assist_pkg::disposition_t disposition,
	input wire logic                        timer_irq_guest,
	input wire logic                        timer_irq_real,
	input wire logic [15:0]                 ext_irq_code,
	input wire logic                        guest_timer_enabled,
	input wire logic                        page0_resident,
	input wire logic                        guest_new_psw_valid,
	input wire logic                        guest_state_change_legal,
	input wire logic                        real_timer_enabled
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// outputs quiet, timer interrupts tied to their causes
	rst_quiet_a: assert property ($rose(rst_n) |-> !instr_done && !timer_irq_guest
		&& !timer_irq_real && disposition == vm_assist_pkg::DISP_NONE)
		else $error("outputs active right after reset");
	done_cause_a: assert property (instr_done |-> $past(instr_valid)
		|| $past(instr_valid, 2)) else $error("done without a request");
	// assist-unit results come two cycles after the request; link and return take one
	assist_lat_a: assert property (instr_done
		&& disposition == vm_assist_pkg::DISP_ASSIST_DONE
		&& $past(instr_bytes[47:40]) == `ASSIST_OPCODE |-> $past(instr_valid, 2))
		else $error("assist result at wrong latency");
	irq_excl_a: assert property (!(timer_irq_guest && timer_irq_real))
		else $error("timer interrupt sent both ways");
	guest_cond_a: assert property (timer_irq_guest |-> $past(guest_timer_enabled
		&& page0_resident && guest_new_psw_valid && guest_state_change_legal))
		else $error("guest interrupt without its conditions");
	real_cond_a: assert property (timer_irq_real |-> $past(real_timer_enabled))
		else $error("real interrupt while real timer disabled");
	real_code_a: assert property (timer_irq_real |-> ##[0:1]
		ext_irq_code == `VTIMER_EXT_CODE) else $error("wrong code on real delivery");
	guest_code_a: assert property (timer_irq_guest |-> ##[0:1]
		ext_irq_code == `RTIMER_EXT_CODE) else $error("wrong code on guest delivery");
	irq_pulse_a: assert property (timer_irq_guest |=> !timer_irq_guest)
		else $error("guest interrupt longer than one cycle");
endmodule

// ===== sim/tb_vm_assist_sequencer.sv
// self-checking bench for the vm assist sequencer
`timescale 1ns/1ps
`include "vm_assist_params.svh"
module tb_vm_assist_sequencer;
	localparam logic [31:0] CR6_ALL = (32'h1 << `CR6_VMA_BIT) | (32'h1 << `CR6_CPA_BIT)
		| (32'h1 << `CR6_VIT_BIT);
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready = 1'b0;
	logic        instr_valid = 1'b0;
	logic [47:0] instr_bytes = 48'h0;
	logic        guest_issued = 1'b0;
	logic        supervisor_state = 1'b0;
	logic        basic_can_simulate = 1'b0;
	logic        expanded_can_simulate = 1'b0;
	logic        real_timer_tick = 1'b0;
	logic        problem_state = 1'b0;
	logic        wait_state = 1'b0;
	logic        page0_resident = 1'b1;
	logic        guest_timer_enabled = 1'b1;
	logic        guest_new_psw_valid = 1'b1;
	logic        guest_state_change_legal = 1'b1;
	logic        real_timer_enabled = 1'b1;
	logic        instr_done;
	logic        timer_irq_guest;
	logic        timer_irq_real;
	logic [15:0] ext_irq_code;
	vm_assist_pkg::disposition_t disposition;
	int          n_fail = 0;
	int          total_checks = 0;
	// opcode, sub byte, flags {guest,super,basic,expanded}, expected disposition
	logic [23:0] rows [16] = '{24'h8200A1, 24'h820092, 24'h800083, 24'hAC0083,
		24'hAD00A1, 24'hB20D91, 24'hB20991, 24'h9F0091, 24'hB20692, 24'hB20492,
		24'hB20892, 24'hE61E46, 24'hE60546, 24'hE61F44, 24'h0A0846, 24'h0A0C46};

	vm_assist_sequencer dut_u (.*);

	// free-running clock
	always #10 clk = ~clk;

	task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chkd(input vm_assist_pkg::disposition_t exp);
		total_checks++;
		if (disposition !== exp) begin
			n_fail++;
			$display("MISMATCH disposition expected %0d seen %0d", exp, disposition);
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk32("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk32("rdata", ed, s_axi_rdata);
		chk32("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask

	// present one instruction and compare its disposition
	task automatic exe(input logic [23:0] t);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_bytes <= {t[23:8], 32'h0};
		guest_issued <= t[7];
		supervisor_state <= t[6];
		basic_can_simulate <= t[5];
		expanded_can_simulate <= t[4];
		@(posedge clk);
		instr_valid <= 1'b0;
		do @(posedge clk); while (!instr_done);
		chkd(vm_assist_pkg::disposition_t'(t[2:0]));
	endtask

	// one real timer decrement, then watch both interrupt outputs
	task automatic tick(input logic eg, input logic er);
		logic g;
		logic r;
		g = 1'b0;
		r = 1'b0;
		@(posedge clk);
		real_timer_tick <= 1'b1;
		@(posedge clk);
		real_timer_tick <= 1'b0;
		repeat (4) begin
			@(posedge clk);
			g = g | timer_irq_guest;
			r = r | timer_irq_real;
		end
		chk32("irq_guest", {31'h0, eg}, {31'h0, g});
		chk32("irq_real", {31'h0, er}, {31'h0, r});
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		axr(`REG_CTRL6, 32'h0, 2'h0);
		axr(8'h40, 32'h0, 2'h2);
		axw(`REG_LEVEL, 32'h5, 2'h2);
		exe(24'hE60545);
		axw(`REG_CTRL6, CR6_ALL, 2'h0);
		axr(`REG_CTRL6, CR6_ALL, 2'h0);
		foreach (rows[i]) exe(rows[i]);
		axr(`REG_LEVEL, 32'h1, 2'h0);
		problem_state <= 1'b1;
		wait_state <= 1'b1;
		tick(1'b0, 1'b0);
		wait_state <= 1'b0;
		problem_state <= 1'b0;
		tick(1'b0, 1'b0);
		axr(`REG_GUEST_TIMER, 32'h0, 2'h0);
		problem_state <= 1'b1;
		tick(1'b1, 1'b0);
		chk32("ext_code", {16'h0, `RTIMER_EXT_CODE}, {16'h0, ext_irq_code});
		axr(`REG_GUEST_TIMER, 32'hFFFFFF00, 2'h0);
		tick(1'b0, 1'b0);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		axr(`REG_CTRL6, 32'h0, 2'h0);
		axw(`REG_CTRL6, 32'h41, 2'h0);
		tick(1'b0, 1'b0);
		axr(`REG_GUEST_TIMER, 32'h0, 2'h0);
		axw(`REG_CTRL6, CR6_ALL, 2'h0);
		guest_timer_enabled <= 1'b0;
		tick(1'b0, 1'b1);
		chk32("ext_code", {16'h0, `VTIMER_EXT_CODE}, {16'h0, ext_irq_code});
		// page 0 away: control block copy keeps counting, page image stays frozen
		page0_resident <= 1'b0;
		tick(1'b0, 1'b0);
		axr(`REG_GUEST_CTRL, 32'hFFFFFE00, 2'h0);
		axr(`REG_GUEST_TIMER, 32'hFFFFFF00, 2'h0);
		page0_resident <= 1'b1;
		axr(`REG_GUEST_TIMER, 32'hFFFFFE00, 2'h0);
		stop_test;
	end

	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		stop_test;
	end
endmodule

bind vm_assist_sequencer vm_assist_props chk_u (.*);
